// ===== hdl/pwm_timer.sv
// Two-channel PWM timer with unbuffered and buffered (paired) outputs.
`timescale 1ns/1ns
// What this block does
// - The clear bit resets counter and prescaler; software uses it at setup.
// - The period limit pair sets the PWM period.
// - The channel compare pair sets the pulse width.
// - Mode 0:1 is unbuffered, mode 1:0 is buffered.
// - Edge/level 1:0 clears output on compare; 1:1 sets it.
// - Channel 0 upper mode bit pairs channels into one buffered output.
// - Channel 0 compare pair first controls the paired output.
// - Channel 0 control governs and reports the paired output.
// - Upper mode bit wins over lower when both are set.
// - With edge/level 1:0 and no overflow toggle the output stays low, giving 0% duty.
// - Max duty plus overflow toggle gives constant 100% duty.
module pwm_timer #(
   parameter int CNT_W = pwm_pkg::CNT_W
) (
   // Clock and reset.
   input  wire logic             core_clk,
   input  wire logic             nrst,
   // Counter control.
   input  wire logic             counter_halt_bit,
   input  wire logic             counter_clear,
   input  wire logic [2:0]       prescale_sel,
   input  wire logic [CNT_W-1:0] period_limit_pair,
   // Channel 0 control.
   input  wire logic             chan0_mode_upper,
   input  wire logic             chan0_mode_lower,
   input  wire logic             chan0_toggle_ovf,
   input  wire logic [1:0]       chan0_els,
   input  wire logic             chan0_max_duty,
   input  wire logic [CNT_W-1:0] chan0_compare_pair,
   // Channel 1 control.
   input  wire logic [1:0]       chan1_mode,
   input  wire logic             chan1_toggle_ovf,
   input  wire logic [1:0]       chan1_els,
   input  wire logic             chan1_max_duty,
   input  wire logic [CNT_W-1:0] chan1_compare_pair,
   // Status.
   output logic [CNT_W-1:0]      count,
   output logic                  overflow,
   output logic                  chan0_flag,
   output logic                  chan1_flag,
   output logic                  paired,
   output logic                  buf_sel,
   // Pins.
   output logic                  chan0_out,
   output logic                  chan1_out,
   output logic                  chan0_out_en,
   output logic                  chan1_out_en
);
   initial begin
      if (CNT_W < 2 || CNT_W > 16) begin
         $error("pwm_timer: CNT_W must lie in 2..16");
      end
   end

   pwm_chan_if #(.W(CNT_W)) ch0 ();
   pwm_chan_if #(.W(CNT_W)) ch1 ();

   pwm_pkg::run_state_e run_state;
   pwm_pkg::run_state_e next_run_state;
   logic [7:0]       prescale;
   logic             tick;
   logic             wrap;
   logic             pair_mode;
   logic             use_alt;
   logic             next_out0;
   logic             next_out1;

   // Channel 0's upper bit pairs the channels and outranks the lower bit.
   assign pair_mode = chan0_mode_upper;

   // Tick taken from the prescaler output selected by software.
   assign tick = (run_state == pwm_pkg::ST_RUNNING) &&
                 (prescale_sel == 3'h0 ||
                  (prescale[prescale_sel - 3'h1] &&
                   (prescale & ((8'h01 << (prescale_sel - 3'h1)) - 8'h01))
                   == 8'h00));
   assign wrap = tick && (count == period_limit_pair);

   // Counter run state: clearing wins, halting stops the count.
   always_comb begin
      next_run_state = run_state;
      case (run_state)
         pwm_pkg::ST_HALTED: begin
            if (counter_clear) next_run_state = pwm_pkg::ST_CLEARING;
            else if (!counter_halt_bit) next_run_state = pwm_pkg::ST_RUNNING;
         end
         pwm_pkg::ST_RUNNING: begin
            if (counter_clear) next_run_state = pwm_pkg::ST_CLEARING;
            else if (counter_halt_bit) next_run_state = pwm_pkg::ST_HALTED;
         end
         pwm_pkg::ST_CLEARING: begin
            if (!counter_clear) begin
               next_run_state = counter_halt_bit ? pwm_pkg::ST_HALTED
                                                 : pwm_pkg::ST_RUNNING;
            end
         end
         default: next_run_state = pwm_pkg::ST_HALTED;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) run_state <= pwm_pkg::ST_HALTED;
      else run_state <= next_run_state;
   end

   // Prescaler runs only while counting and is zeroed by the clear bit.
   always_ff @(posedge core_clk) begin
      if (!nrst || next_run_state == pwm_pkg::ST_CLEARING) begin
         prescale <= pwm_pkg::PRESCALE_RESET;
      end else if (run_state == pwm_pkg::ST_RUNNING) begin
         prescale <= prescale + 8'h01;
      end
   end

   // Main counter; restarting at zero on the limit keeps the period exact.
   always_ff @(posedge core_clk) begin
      if (!nrst || next_run_state == pwm_pkg::ST_CLEARING) begin
         count <= CNT_W'(pwm_pkg::CNT_RESET);
      end else if (wrap) begin
         count <= CNT_W'(pwm_pkg::CNT_RESET);
      end else if (tick) begin
         count <= count + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) overflow <= 1'b0;
      else overflow <= wrap;
   end

   // Buffered mode swaps the live compare channel only at overflow, so a
   // width written to the idle channel never tears a running period.
   always_ff @(posedge core_clk) begin
      if (!nrst || !pair_mode) begin
         use_alt <= 1'b0;
      end else if (wrap) begin
         use_alt <= ~use_alt;
      end
   end

   // Channel settings; in paired mode channel 0's control governs the paired output.
   always_comb begin
      ch0.mode = pair_mode ? pwm_pkg::MODE_BUF
                           : {1'b0, chan0_mode_lower};
      ch0.toggle_ovf = chan0_toggle_ovf;
      ch0.els = chan0_els;
      ch0.max_duty = chan0_max_duty;
      ch0.compare = (pair_mode && use_alt) ? chan1_compare_pair
                                           : chan0_compare_pair;
      ch1.mode = chan1_mode;
      ch1.toggle_ovf = chan1_toggle_ovf;
      ch1.els = chan1_els;
      ch1.max_duty = chan1_max_duty;
      ch1.compare = chan1_compare_pair;
   end

   pwm_compare #(.W(CNT_W)) u_cmp0 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .count    (count),
      .tick     (tick),
      .ch       (ch0)
   );

   pwm_compare #(.W(CNT_W)) u_cmp1 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .count    (count),
      .tick     (tick),
      .ch       (ch1)
   );

   // Output action for one channel; overflow toggles, compare drives the
   // edge/level action, and max duty with overflow toggle holds the output high for 100%.
   function automatic logic pin_next(input logic cur,
                                     input logic [1:0] els,
                                     input logic tov,
                                     input logic maxd,
                                     input logic ovf,
                                     input logic hit);
      logic v;
      v = cur;
      if (tov && maxd) begin
         v = 1'b1;
      end else begin
         if (ovf && tov) v = ~v;
         if (hit) begin
            case (els)
               pwm_pkg::ELS_CLEAR: v = 1'b0;
               pwm_pkg::ELS_SET: v = 1'b1;
               pwm_pkg::ELS_TOGGLE: v = ~v;
               default: v = v;
            endcase
         end
      end
      return v;
   endfunction

   // Overflow is a registered pulse so it lines up with the compare hits.
   always_comb begin
      next_out0 = pin_next(chan0_out, ch0.els, ch0.toggle_ovf,
                           ch0.max_duty, overflow, ch0.cmp_hit);
      next_out1 = pin_next(chan1_out, ch1.els, ch1.toggle_ovf,
                           ch1.max_duty, overflow, ch1.cmp_hit);
   end

   // Channel outputs; in paired mode channel 1's pin is released.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         chan0_out <= 1'b0;
         chan1_out <= 1'b0;
      end else begin
         if (ch0.els != pwm_pkg::ELS_OFF) chan0_out <= next_out0;
         if (!pair_mode && ch1.els != pwm_pkg::ELS_OFF) begin
            chan1_out <= next_out1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         chan0_out_en <= 1'b0;
         chan1_out_en <= 1'b0;
      end else begin
         chan0_out_en <= (ch0.els != pwm_pkg::ELS_OFF) &&
                         (ch0.mode != 2'h0);
         chan1_out_en <= !pair_mode && (ch1.els != pwm_pkg::ELS_OFF) &&
                         (ch1.mode != 2'h0);
      end
   end

   // Status flags: channel 0's flag reports either compare of the pair.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         chan0_flag <= 1'b0;
         chan1_flag <= 1'b0;
         paired     <= 1'b0;
         buf_sel    <= 1'b0;
      end else begin
         chan0_flag <= ch0.cmp_hit;
         chan1_flag <= ch1.cmp_hit && !pair_mode;
         paired     <= pair_mode;
         buf_sel    <= use_alt;
      end
   end
endmodule // pwm_timer

// ===== hdl/pwm_pkg.sv
// Shared constants and types of the two-channel PWM timer.
package pwm_pkg;
   localparam int CNT_W = 16;
   localparam logic [1:0] MODE_UNBUF = 2'h1;
   localparam logic [1:0] MODE_BUF = 2'h2;
   localparam logic [1:0] ELS_CLEAR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [7:0] PRESCALE_RESET = 8'h00;
   localparam logic [2:0] PS_RESET = 3'h0;
   typedef enum logic [1:0] {
      ST_HALTED = 2'b00,
      ST_RUNNING = 2'b01,
      ST_CLEARING = 2'b11
   } run_state_e;
endpackage

// ===== hdl/pwm_chan_if.sv
// Interface carrying a channel's settings and its compare event.
`timescale 1ns/1ns
interface pwm_chan_if #(parameter int W = 16);
   logic [1:0]   mode;
   logic         toggle_ovf;
   logic [1:0]   els;
   logic         max_duty;
   logic [W-1:0] compare;
   logic         cmp_hit;
   modport ctl (output mode, toggle_ovf, els, max_duty, compare,
                input cmp_hit);
   modport chan (input mode, toggle_ovf, els, max_duty, compare,
                 output cmp_hit);
endinterface

// ===== hdl/pwm_compare.sv
// Compare detector: pulses when the running counter matches a width.
`timescale 1ns/1ns
module pwm_compare #(
   parameter int W = 16
) (
   // Clock and reset.
   input  wire logic         core_clk,
   input  wire logic         nrst,
   // Counter state.
   input  wire logic [W-1:0] count,
   input  wire logic         tick,
   // Channel settings and event.
   pwm_chan_if.chan          ch
);
   // The hit is a registered pulse, so the output path has two stages.
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ch.cmp_hit <= 1'b0;
      end else begin
         ch.cmp_hit <= tick && (count == ch.compare);
      end
   end
endmodule // pwm_compare

// ===== test/pwm_timer_monitor.sv
// Port-level assertions for the two-channel PWM timer.
`timescale 1ns/1ns
module pwm_timer_monitor #(
   parameter int CNT_W = 16
) (
   // Clock, reset and counter control.
   input wire logic             core_clk,
   input wire logic             nrst,
   input wire logic             counter_halt_bit,
   input wire logic             counter_clear,
   input wire logic [CNT_W-1:0] period_limit_pair,
   // Channel 0 control.
   input wire logic             chan0_mode_upper,
   input wire logic             chan0_toggle_ovf,
   input wire logic [1:0]       chan0_els,
   input wire logic             chan0_max_duty,
   // Status and pin.
   input wire logic [CNT_W-1:0] count,
   input wire logic             overflow,
   input wire logic             chan0_flag,
   input wire logic             paired,
   input wire logic             buf_sel,
   input wire logic             chan0_out
);
   // All checks run on the one core clock and sleep through reset.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Compare events with a clearing or setting pin action.
   sequence s_clr_hit;
      chan0_flag && chan0_els == pwm_pkg::ELS_CLEAR && !chan0_max_duty;
   endsequence
   sequence s_set_hit;
      chan0_flag && chan0_els == pwm_pkg::ELS_SET;
   endsequence
   wrap_zero_a: assert property (overflow |-> count == '0 &&
      $past(count) == $past(period_limit_pair))
      else $error("overflow without wrap at limit");
   clear_hold_a: assert property (counter_clear |=> count == '0)
      else $error("count not cleared");
   halt_freeze_a: assert property (
      (counter_halt_bit && !counter_clear)[*3] |-> $stable(count))
      else $error("count moved while halted");
   // The pin acts at the same edge that raises the flag; one cycle later an
   // overflow toggle may already have moved it, so look in the flag cycle.
   clear_action_a: assert property (s_clr_hit |-> !chan0_out)
      else $error("pin not cleared on compare");
   set_action_a: assert property (s_set_hit |-> chan0_out)
      else $error("pin not set on compare");
   max_duty_a: assert property ((chan0_max_duty && chan0_toggle_ovf &&
      chan0_els != pwm_pkg::ELS_OFF)[*3] |-> chan0_out)
      else $error("full duty pin low");
   zero_duty_a: assert property ((!chan0_toggle_ovf && !chan0_max_duty &&
      chan0_els == pwm_pkg::ELS_CLEAR)[*3] ##0 !chan0_out |=> !chan0_out)
      else $error("pin moved without overflow toggle");
   toggle_ovf_a: assert property (overflow && chan0_toggle_ovf &&
      !chan0_max_duty && !chan0_flag && chan0_els == pwm_pkg::ELS_CLEAR
      |=> chan0_out != $past(chan0_out))
      else $error("pin not toggled on overflow");
   pair_upper_a: assert property (chan0_mode_upper[*2] |-> paired)
      else $error("channels not paired");
   pair_start_a: assert property ($rose(paired) |-> !buf_sel)
      else $error("pairing did not start on channel 0");
endmodule // pwm_timer_monitor

bind pwm_timer pwm_timer_monitor #(.CNT_W(CNT_W)) u_mon (.core_clk,
   .nrst, .counter_halt_bit, .counter_clear, .period_limit_pair,
   .chan0_mode_upper, .chan0_toggle_ovf, .chan0_els, .chan0_max_duty,
   .count, .overflow, .chan0_flag, .paired, .buf_sel, .chan0_out);

// ===== test/tb_pwm_timer.sv
// Self-checking bench for the two-channel PWM timer.
`timescale 1ns/1ns
module tb_pwm_timer;
   logic core_clk = 1'b0, nrst = 1'b0, counter_halt_bit = 1'b1;
   logic counter_clear = 1'b1, chan0_mode_upper = 1'b0;
   logic chan0_mode_lower = 1'b1, chan0_toggle_ovf = 1'b1;
   logic chan0_max_duty = 1'b0, chan1_toggle_ovf = 1'b1;
   logic chan1_max_duty = 1'b0, chan0_out, chan1_out, chan0_out_en;
   logic overflow, chan0_flag, chan1_flag, paired, buf_sel, chan1_out_en;
   logic [2:0]  prescale_sel = 3'h0;
   logic [1:0]  chan0_els = 2'h2, chan1_els = 2'h2;
   logic [1:0]  chan1_mode = pwm_pkg::MODE_UNBUF;
   logic [15:0] period_limit_pair = 16'h0007, count;
   logic [15:0] chan0_compare_pair = 16'h0002;
   logic [15:0] chan1_compare_pair = 16'h0002;
   int          mismatches = 0, samples_checked = 0, hi0, hi1;
   typedef struct {int l; int c; logic [1:0] e; logic t; logic m;
      int h;} row_s;
   // Limit, width, pin action, overflow toggle, full duty, high cycles.
   row_s rows[6] = '{'{7, 2, 2'h2, 1, 0, 3}, '{7, 2, 2'h3, 1, 0, 5},
      '{9, 1, 2'h2, 1, 0, 2}, '{7, 2, 2'h2, 0, 0, 0},
      '{7, 2, 2'h2, 1, 1, 8}, '{15, 14, 2'h2, 1, 0, 15}};
   pwm_timer u_dut (.core_clk, .nrst, .counter_halt_bit, .counter_clear,
      .prescale_sel, .period_limit_pair, .chan0_mode_upper,
      .chan0_mode_lower, .chan0_toggle_ovf, .chan0_els, .chan0_max_duty,
      .chan0_compare_pair, .chan1_mode, .chan1_toggle_ovf, .chan1_els,
      .chan1_max_duty, .chan1_compare_pair, .count, .overflow, .chan0_flag,
      .chan1_flag, .paired, .buf_sel, .chan0_out, .chan1_out,
      .chan0_out_en, .chan1_out_en);
   // Free-running core clock.
   always #25 core_clk = ~core_clk;
   // Compares one value and counts the result.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Halt and clear first, load settings, then release clear and halt.
   task automatic setup(input row_s r);
      counter_halt_bit = 1'b1;
      counter_clear = 1'b1;
      period_limit_pair = 16'(r.l);
      chan0_compare_pair = 16'(r.c);
      chan0_els = r.e;
      chan1_els = r.e;
      chan0_toggle_ovf = r.t;
      chan1_toggle_ovf = r.t;
      chan0_max_duty = r.m;
      chan1_max_duty = r.m;
      cycles(2);
      counter_clear = 1'b0;
      cycles(1);
      counter_halt_bit = 1'b0;
      cycles(3 * (r.l + 1));
   endtask
   // Counts high pin cycles over a window of n clocks.
   task automatic measure(input int n);
      hi0 = 0;
      hi1 = 0;
      repeat (n) begin
         @(negedge core_clk);
         hi0 += int'(chan0_out);
         hi1 += int'(chan1_out);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Table of duty cases, then pairing, halt, clear, pin-off and reset.
   initial begin
      cycles(2);
      check(count, 16'h0000);
      check({15'h0000, chan0_out}, 16'h0000);
      nrst = 1'b1;
      foreach (rows[i]) begin
         chan1_compare_pair = 16'(rows[i].c);
         setup(rows[i]);
         measure(rows[i].l + 1);
         check(16'(hi0), 16'(rows[i].h));
         check(16'(hi1), 16'(rows[i].h));
         check({15'h0000, chan0_out_en}, 16'h0001);
         check({15'h0000, chan1_out_en}, 16'h0001);
      end
      chan0_mode_upper = 1'b1;
      chan1_compare_pair = 16'h0005;
      setup(rows[0]);
      check({15'h0000, paired}, 16'h0001);
      check({15'h0000, chan1_out_en}, 16'h0000);
      measure(16);
      check(16'(hi0), 16'h0009);
      check({15'h0000, chan1_flag}, 16'h0000);
      counter_halt_bit = 1'b1;
      cycles(2);
      hi0 = int'(count);
      cycles(3);
      check(count, 16'(hi0));
      counter_clear = 1'b1;
      cycles(2);
      check(count, 16'h0000);
      chan0_els = pwm_pkg::ELS_OFF;
      cycles(3);
      check({15'h0000, chan0_out_en}, 16'h0000);
      nrst = 1'b0;
      cycles(2);
      check({15'h0000, paired}, 16'h0000);
      complete_run();
   end
endmodule // tb_pwm_timer
